/* bt_command_engine.sv */
// How it works
// - status is two bytes; low byte flags, high byte reserved
// - temp busy reads 1 during conversion, 0 once result is stored
// - nonvolatile busy reads 1 during a nonvolatile copy, 10 ms
// - lock flag reads 1 while page one is locked
// - read scratch from start address; reserved and past-end bytes read FFh
// - write scratch from start address, advancing one byte per data byte
// - copy scratch one down: 24 bytes, no address, busy set
// - copy scratch two down: 8 bytes, no address, busy set
// - copy scratch three to backed page: 32 bytes, no address
// - copy page one up: 24 bytes, allowed while locked
// - copy pages two and three up, full page, no address
// - no direct master path to persistent or backed pages
// - lock refuses later downward copies of page one
// - unlock accepts downward copies of page one again
// - convert sets temp busy; result stored and flag cleared at end
// - memory commands stay usable during a conversion
// - read registers from start address; past page end reads FFh
// - increment adds one to cycle count, no address or data
// - reset cycle count clears it to zero
// - cycle count is two-byte binary, changed only by its commands
// - fixed read-only 16-bit identifier
// - bytes travel least significant bit first
// - half-degree result sits at the lowest temperature address
`timescale 1ns/1ns
`include "bt_defs.svh"
module bt_command_engine
   import bt_pkg::*;
#(
   parameter int unsigned NV_COPY_CYCLES = `BT_NV_COPY_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic bus_reset,
   input wire bt_byte_t rx,
   input wire logic rd_req,
   output bt_byte_t rd,
   output logic temp_start,
   input wire bt_temp_t temp_in,
   output logic [7:0] status_flags
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   bt_state_t state;
   bt_mode_t mode;
   logic [7:0] addr;
   logic temp_busy;
   logic locked;
   logic [7:0] temp_half;
   logic [7:0] temp_whole;
   logic [15:0] charge_cycle_count;
   logic [7:0] scratch [0:`BT_SCRATCH_SIZE-1];
   // persistent page one, page two and backed page at scratch offsets
   logic [7:0] persist [0:`BT_SCRATCH_SIZE-1];
   logic nonvolatile_busy;

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   // bit 0 of every byte is the first bit on the wire
   wire logic rx_take = clk_en && rx.valid && !bus_reset;
   wire logic cmd_take = rx_take && state == BT_IDLE;
   wire logic [7:0] cmd = rx.data;
   wire logic nv_free = !nonvolatile_busy;
   wire logic is_rd_scratch = cmd == `BT_CMD_RD_SCRATCH;
   wire logic is_wr_scratch = cmd == `BT_CMD_WR_SCRATCH;
   wire logic is_rd_regs = cmd == `BT_CMD_RD_REGS;
   wire logic addr_cmd = is_rd_scratch || is_wr_scratch || is_rd_regs;
   wire logic down_one = cmd_take && cmd == `BT_CMD_DOWN_ONE
      && nv_free && !locked;
   wire logic down_two = cmd_take && cmd == `BT_CMD_DOWN_TWO
      && nv_free;
   wire logic down_three = cmd_take && cmd == `BT_CMD_DOWN_THREE;
   wire logic up_one = cmd_take && cmd == `BT_CMD_UP_ONE;
   wire logic up_two = cmd_take && cmd == `BT_CMD_UP_TWO;
   wire logic up_three = cmd_take && cmd == `BT_CMD_UP_THREE;
   wire logic lock_cmd = cmd_take && cmd == `BT_CMD_LOCK && nv_free;
   wire logic unlock_cmd = cmd_take && cmd == `BT_CMD_UNLOCK && nv_free;
   wire logic cycle_inc = cmd_take && cmd == `BT_CMD_CYCLE_INC && nv_free;
   wire logic cycle_clr = cmd_take && cmd == `BT_CMD_CYCLE_CLR && nv_free;
   wire logic convert = cmd_take && cmd == `BT_CMD_CONVERT;
   wire logic nv_start = down_one || down_two || lock_cmd || unlock_cmd
      || cycle_inc || cycle_clr;
   wire logic temp_done = clk_en && temp_in.done;
   wire logic wr_stb = rx_take && state == BT_WRITE;
   wire logic rd_stb = clk_en && rd_req && !bus_reset && state == BT_READ;
   wire logic [7:0] addr_next = (addr == 8'hFF) ? addr : addr + 8'h01;

   // ----------------------------------------
   // read selection
   // ----------------------------------------
   wire logic in_scratch = addr <= `BT_PAGE_ONE_END
      || (addr >= `BT_PAGE_TWO_BASE && addr <= `BT_PAGE_TWO_END)
      || (addr >= `BT_PAGE_THREE_BASE && addr <= `BT_SCRATCH_END);
   wire logic [6:0] scr_idx = in_scratch ? addr[6:0] : 7'h00;
   // of the memory pages, only scratch is visible to reads
   wire logic [7:0] scratch_byte = in_scratch ? scratch[scr_idx]
      : `BT_FILL_BYTE;
   wire logic [7:0] pack_identifier_lo = 8'(`BT_PACK_ID & 16'h00FF);
   wire logic [7:0] pack_identifier_hi = 8'(`BT_PACK_ID >> 8);
   wire logic [7:0] reg_byte =
      addr == `BT_TEMP_LO ? temp_half :
      addr == `BT_TEMP_HI ? temp_whole :
      addr == `BT_STATUS_LO ? status_flags :
      addr == `BT_STATUS_HI ? `BT_STATUS_HI_VALUE :
      addr == `BT_ID_LO ? pack_identifier_lo :
      addr == `BT_ID_HI ? pack_identifier_hi :
      addr == `BT_COUNT_LO ? charge_cycle_count[7:0] :
      addr == `BT_COUNT_HI ? charge_cycle_count[15:8] :
      `BT_FILL_BYTE;
   wire logic [7:0] fetch = mode == BT_M_RD_REGS ? reg_byte : scratch_byte;

   // ----------------------------------------
   // status byte
   // ----------------------------------------
   assign status_flags = 8'(({7'h00, temp_busy} << `BT_TB_BIT)
      | ({7'h00, nonvolatile_busy} << `BT_NVB_BIT)
      | ({7'h00, locked} << `BT_LOCK_BIT));

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= BT_IDLE;
         mode <= BT_M_RD_SCRATCH;
         addr <= 8'h00;
      end else if (clk_en) begin
         if (bus_reset) begin
            state <= BT_IDLE;
         end else begin
            unique case (state)
               BT_IDLE: if (rx.valid) begin
                  // unknown codes park the engine until bus reset
                  state <= addr_cmd ? BT_ADDR : BT_DONE;
                  mode <= is_rd_regs ? BT_M_RD_REGS
                     : is_wr_scratch ? BT_M_WR_SCRATCH : BT_M_RD_SCRATCH;
               end
               BT_ADDR: if (rx.valid) begin
                  addr <= rx.data;
                  state <= mode == BT_M_WR_SCRATCH ? BT_WRITE : BT_READ;
               end
               BT_WRITE: if (rx.valid) begin
                  addr <= addr_next;
               end
               BT_READ: if (rd_req) begin
                  addr <= addr_next;
               end
               BT_DONE: state <= BT_DONE;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd <= '0;
         temp_start <= 1'b0;
      end else if (clk_en) begin
         rd.valid <= rd_stb;
         rd.data <= rd_stb ? fetch : rd.data;
         temp_start <= convert;
      end
   end

   // ----------------------------------------
   // flags, temperature, counter
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         temp_busy <= 1'b0;
         temp_half <= `BT_MEM_RESET;
         temp_whole <= `BT_MEM_RESET;
         locked <= 1'b0;
         charge_cycle_count <= `BT_COUNT_RESET;
      end else if (clk_en) begin
         // a new convert wins over a finishing one
         temp_busy <= convert || (temp_busy && !temp_in.done);
         if (temp_in.done) begin
            temp_half <= temp_in.half_deg;
            temp_whole <= temp_in.whole_deg;
         end
         if (lock_cmd) begin
            locked <= 1'b1;
         end else if (unlock_cmd) begin
            locked <= 1'b0;
         end
         if (cycle_inc) begin
            charge_cycle_count <= charge_cycle_count + 16'h0001;
         end else if (cycle_clr) begin
            charge_cycle_count <= `BT_COUNT_RESET;
         end
      end
   end

   bt_busy_timer #(
      .CYCLES(NV_COPY_CYCLES)
   ) u_nv_timer (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .start(nv_start),
      .busy(nonvolatile_busy)
   );

   // ----------------------------------------
   // scratch and persistent bytes
   // ----------------------------------------
   for (genvar i = 0; i < `BT_SCRATCH_SIZE; i++) begin : g_ent
      localparam logic [7:0] AT = 8'(i);
      localparam int PG = i < 24 ? 1 : (i >= 32 && i < 40) ? 2
         : i >= 64 ? 3 : 0;
      if (PG != 0) begin : g_pop
         // reserved offsets get no storage at all
         wire logic up = PG == 1 ? up_one : PG == 2 ? up_two : up_three;
         wire logic down = PG == 1 ? down_one : PG == 2 ? down_two
            : down_three;
         wire logic hit = wr_stb && addr == AT;
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               scratch[i] <= `BT_MEM_RESET;
            end else if (clk_en) begin
               if (up) begin
                  scratch[i] <= persist[i];
               end else if (hit) begin
                  scratch[i] <= rx.data;
               end
            end
         end
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               persist[i] <= `BT_MEM_RESET;
            end else if (clk_en && down) begin
               persist[i] <= scratch[i];
            end
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   status_high_a: assert property (rd_stb && mode == BT_M_RD_REGS
      && addr == `BT_STATUS_HI |=> rd.valid && rd.data == 8'h00)
      else $error("status high byte not zero");
   temp_set_a: assert property (convert |=> temp_busy
      && status_flags[`BT_TB_BIT] ##1 temp_busy || $past(temp_done))
      else $error("temp busy not set by convert");
   temp_store_a: assert property (temp_done && !convert
      |=> !temp_busy && temp_half == $past(temp_in.half_deg))
      else $error("temperature result not stored");
   nv_copy_a: assert property (down_one |=> nonvolatile_busy
      && persist[0] == $past(scratch[0]))
      else $error("page one copy did not start");
   lock_refuse_a: assert property (cmd_take && locked
      && cmd == `BT_CMD_DOWN_ONE |=> persist[5] == $past(persist[5]))
      else $error("locked page one was overwritten");
   count_inc_a: assert property (cycle_inc
      |=> charge_cycle_count == $past(charge_cycle_count) + 16'h0001)
      else $error("cycle count did not increment");
   count_clr_a: assert property (cycle_clr
      |=> charge_cycle_count == `BT_COUNT_RESET)
      else $error("cycle count not cleared");
   past_end_a: assert property (rd_stb && mode == BT_M_RD_SCRATCH
      && addr > `BT_SCRATCH_END |=> rd.data == 8'hFF)
      else $error("past-end scratch read not all ones");
   id_read_a: assert property (rd_stb && mode == BT_M_RD_REGS
      && addr == `BT_ID_HI |=> rd.data == pack_identifier_hi)
      else $error("identifier read wrong");
   bus_abort_a: assert property (clk_en && bus_reset
      |=> state == BT_IDLE && nonvolatile_busy
      == ($past(nonvolatile_busy) && !$past(u_nv_timer.last)))
      else $error("bus reset did not abort command");
   rd_answer_a: assert property (rd_stb |=> rd.valid)
      else $error("read slot got no answer");
   wr_store_a: assert property (wr_stb && addr == 8'h00
      |=> scratch[0] == $past(rx.data))
      else $error("write data not stored");
   up_one_a: assert property (up_one
      |=> scratch[0] == $past(persist[0]))
      else $error("page one copy up failed");
   lock_clear_a: assert property (unlock_cmd
      |=> !locked && !status_flags[`BT_LOCK_BIT])
      else $error("unlock did not clear lock");
   temp_pulse_a: assert property (convert |=> temp_start)
      else $error("no conversion start pulse");

   write_read_c: cover property (wr_stb ##[1:40] rd_stb);
   bus_abort_c: cover property (state == BT_WRITE && bus_reset);
   locked_copy_c: cover property (locked && up_one);
   convert_done_c: cover property (convert ##[1:50] temp_done);
endmodule

/* bt_defs.svh */
`ifndef BT_DEFS_SVH
`define BT_DEFS_SVH

// ----------------------------------------
// command codes
// ----------------------------------------
`define BT_CMD_RD_SCRATCH 8'h11
`define BT_CMD_WR_SCRATCH 8'h17
`define BT_CMD_DOWN_ONE 8'h22
`define BT_CMD_DOWN_TWO 8'h25
`define BT_CMD_DOWN_THREE 8'h28
`define BT_CMD_UP_ONE 8'h71
`define BT_CMD_UP_TWO 8'h77
`define BT_CMD_UP_THREE 8'h7A
`define BT_CMD_LOCK 8'h43
`define BT_CMD_UNLOCK 8'h44
`define BT_CMD_CONVERT 8'hD2
`define BT_CMD_RD_REGS 8'hB2
`define BT_CMD_CYCLE_INC 8'hB5
`define BT_CMD_CYCLE_CLR 8'hB8

// ----------------------------------------
// address map
// ----------------------------------------
`define BT_PAGE_ONE_END 8'h17
`define BT_PAGE_TWO_BASE 8'h20
`define BT_PAGE_TWO_END 8'h27
`define BT_PAGE_THREE_BASE 8'h40
`define BT_SCRATCH_END 8'h5F
`define BT_SCRATCH_SIZE 96
`define BT_TEMP_LO 8'h60
`define BT_TEMP_HI 8'h61
`define BT_STATUS_LO 8'h62
`define BT_STATUS_HI 8'h63
`define BT_ID_LO 8'h80
`define BT_ID_HI 8'h81
`define BT_COUNT_LO 8'h82
`define BT_COUNT_HI 8'h83

// ----------------------------------------
// status fields and fill values
// ----------------------------------------
`define BT_TB_BIT 0
`define BT_NVB_BIT 1
`define BT_LOCK_BIT 2
`define BT_STATUS_HI_VALUE 8'h00
`define BT_FILL_BYTE 8'hFF
`define BT_MEM_RESET 8'h00
`define BT_COUNT_RESET 16'h0000
// arbitrary identification value
`define BT_PACK_ID 16'h5A3C

// ----------------------------------------
// timing
// ----------------------------------------
`define BT_CLK_KHZ 100000
`define BT_NV_COPY_MIN_MS 2
`define BT_NV_COPY_MAX_MS 10
`define BT_NV_COPY_CYCLES (`BT_NV_COPY_MAX_MS * `BT_CLK_KHZ)

`endif

/* bt_pkg.sv */
package bt_pkg;
   typedef enum logic [2:0] {
      BT_IDLE, BT_ADDR, BT_WRITE, BT_READ, BT_DONE
   } bt_state_t;
   typedef enum logic [1:0] {
      BT_M_RD_SCRATCH, BT_M_WR_SCRATCH, BT_M_RD_REGS
   } bt_mode_t;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } bt_byte_t;
   typedef struct packed {
      logic done;
      logic [7:0] half_deg;
      logic [7:0] whole_deg;
   } bt_temp_t;
endpackage

/* bt_busy_timer.sv */
`timescale 1ns/1ns
`include "bt_defs.svh"
module bt_busy_timer
   import bt_pkg::*;
#(
   parameter int unsigned CYCLES = `BT_NV_COPY_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic start,
   output logic busy
);
   // ----------------------------------------
   // countdown
   // ----------------------------------------
   logic [19:0] remain;
   wire logic last = (remain == 20'h00001);
   wire logic [19:0] load = 20'(CYCLES);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         busy <= 1'b0;
         remain <= 20'h00000;
      end else if (clk_en) begin
         if (start && !busy) begin
            busy <= 1'b1;
            remain <= load;
         end else if (busy) begin
            busy <= !last;
            remain <= remain - 20'h00001;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   busy_start_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      start && !busy && clk_en |=> busy[*8])
      else $error("busy did not hold after start");
   busy_end_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      busy && last && clk_en |=> !busy)
      else $error("busy did not drop at end of count");
   busy_cycle_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
      busy ##1 !busy);
endmodule

/* bt_master_model.sv */
`timescale 1ns/1ns
`include "bt_defs.svh"
module bt_master_model
   import bt_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [7:0] status_flags,
   output bt_byte_t rx,
   output logic rd_req,
   output logic bus_reset
);
   // ----------------------------------------
   // idle levels
   // ----------------------------------------
   initial begin
      rx = '{valid: 1'b0, data: 8'h00};
      rd_req = 1'b0;
      bus_reset = 1'b0;
   end

   // ----------------------------------------
   // byte transfers
   // ----------------------------------------
   // bus reset, then bytes; bit 0 is the first bit on the wire
   task automatic send(input logic [7:0] b[$]);
      @(posedge ref_clk);
      bus_reset <= 1'b1;
      @(posedge ref_clk);
      bus_reset <= 1'b0;
      foreach (b[i]) begin
         rx <= '{valid: 1'b1, data: b[i]};
         @(posedge ref_clk);
      end
      rx <= '{valid: 1'b0, data: ~b[b.size()-1]};
   endtask

   // command, start address, then n read slots
   task automatic read(input logic [7:0] cmd, addr, input int n);
      send({cmd, addr});
      rd_req <= 1'b1;
      repeat (n) @(posedge ref_clk);
      rd_req <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask

   // poll the busy flag until clear, counting cycles
   task automatic wait_nv(output int n);
      #1;
      n = 0;
      while (status_flags[`BT_NVB_BIT] === 1'b1 && n < 200) begin
         n++;
         @(posedge ref_clk);
         #1;
      end
   endtask
endmodule

/* tb.sv */
`timescale 1ns/1ns
`include "bt_defs.svh"
module tb
   import bt_pkg::*;
();
   localparam int unsigned NVC = 16;
   localparam logic [15:0] ID = `BT_PACK_ID;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic clk_en = 1'b1;
   bt_byte_t rx;
   bt_byte_t rd;
   logic rd_req;
   logic bus_reset;
   logic temp_start;
   bt_temp_t temp_in = '{done: 1'b0, half_deg: 8'h00, whole_deg: 8'h00};
   logic [7:0] status_flags;
   logic [7:0] expq[$];
   logic [7:0] pg [2][3] = '{'{`BT_CMD_DOWN_TWO, `BT_CMD_UP_TWO, 8'h27},
      '{`BT_CMD_DOWN_THREE, `BT_CMD_UP_THREE, 8'h5F}};
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   int seed = 45;
   int n;
   logic [7:0] a, b, c;

   // ----------------------------------------
   // clock, design and far side
   // ----------------------------------------
   always #5 ref_clk = ~ref_clk;

   bt_command_engine #(.NV_COPY_CYCLES(NVC)) dut (.ref_clk(ref_clk),
      .reset_n(reset_n), .clk_en(clk_en), .bus_reset(bus_reset), .rx(rx),
      .rd_req(rd_req), .rd(rd), .temp_start(temp_start), .temp_in(temp_in),
      .status_flags(status_flags));

   bt_master_model m (.ref_clk(ref_clk), .status_flags(status_flags),
      .rx(rx), .rd_req(rd_req), .bus_reset(bus_reset));

   // ----------------------------------------
   // checking and closing
   // ----------------------------------------
   task automatic check(input string what, input logic [15:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic expect_rd(input logic [7:0] cmd, addr,
      input logic [7:0] e[$]);
      foreach (e[i]) expq.push_back(e[i]);
      m.read(cmd, addr, e.size());
   endtask

   task automatic nv_cmd(input logic [7:0] code, input int exp_n);
      m.send({code});
      m.wait_nv(n);
      check("nv busy cycles", n[15:0], exp_n[15:0]);
   endtask

   // read answers against the oldest note; cycle limit
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         test_done;
      end
      if (rd.valid === 1'b1) begin
         if (expq.size() == 0) begin
            check("unexpected rd", 16'h0001, 16'h0000);
         end else begin
            check("rd.data", {8'h00, rd.data},
               {8'h00, expq.pop_front()});
         end
      end
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      a = 8'($random(seed));
      b = 8'($random(seed));
      c = 8'($random(seed));
      @(posedge ref_clk);
      #1;
      check("status", {8'h00, status_flags}, 16'h0000);
      expect_rd(`BT_CMD_RD_REGS, `BT_STATUS_LO,
         {8'h00, 8'h00, 8'hFF});
      expect_rd(`BT_CMD_RD_REGS, `BT_ID_LO,
         {ID[7:0], ID[15:8], 8'h00, 8'h00, 8'hFF});
      m.send({`BT_CMD_WR_SCRATCH, 8'h16, a, b, c, a});
      expect_rd(`BT_CMD_RD_SCRATCH, 8'h16, {a, b, 8'hFF, 8'hFF});
      expect_rd(`BT_CMD_RD_SCRATCH, `BT_SCRATCH_END, {8'h00, 8'hFF});
      m.send({`BT_CMD_WR_SCRATCH, 8'h00, a});
      nv_cmd(`BT_CMD_DOWN_ONE, NVC);
      m.send({`BT_CMD_WR_SCRATCH, 8'h00, b});
      m.send({`BT_CMD_UP_ONE});
      expect_rd(`BT_CMD_RD_SCRATCH, 8'h00, {a});
      nv_cmd(`BT_CMD_LOCK, NVC);
      check("lock flag", {8'h00, status_flags}, 16'h0004);
      m.send({`BT_CMD_WR_SCRATCH, 8'h00, b});
      nv_cmd(`BT_CMD_DOWN_ONE, 0);
      m.send({`BT_CMD_UP_ONE});
      expect_rd(`BT_CMD_RD_SCRATCH, 8'h00, {a});
      nv_cmd(`BT_CMD_UNLOCK, NVC);
      check("lock flag", {8'h00, status_flags}, 16'h0000);
      m.send({`BT_CMD_WR_SCRATCH, 8'h00, b});
      nv_cmd(`BT_CMD_DOWN_ONE, NVC);
      m.send({`BT_CMD_WR_SCRATCH, 8'h00, c});
      m.send({`BT_CMD_UP_ONE});
      expect_rd(`BT_CMD_RD_SCRATCH, 8'h00, {b});
      foreach (pg[i]) begin
         m.send({`BT_CMD_WR_SCRATCH, pg[i][2], a});
         nv_cmd(pg[i][0], (i == 0) ? NVC : 0);
         m.send({`BT_CMD_WR_SCRATCH, pg[i][2], b});
         m.send({pg[i][1]});
         expect_rd(`BT_CMD_RD_SCRATCH, pg[i][2], {a});
      end
      m.send({`BT_CMD_CONVERT});
      #1;
      check("temp start", {15'h0000, temp_start}, 16'h0001);
      check("temp busy", {8'h00, status_flags}, 16'h0001);
      m.send({`BT_CMD_WR_SCRATCH, 8'h40, c});
      expect_rd(`BT_CMD_RD_SCRATCH, 8'h40, {c});
      #1;
      check("temp busy", {8'h00, status_flags}, 16'h0001);
      @(posedge ref_clk);
      temp_in <= '{done: 1'b1, half_deg: a, whole_deg: b};
      @(posedge ref_clk);
      temp_in <= '{done: 1'b0, half_deg: ~a, whole_deg: ~b};
      #1;
      check("temp busy", {8'h00, status_flags}, 16'h0000);
      expect_rd(`BT_CMD_RD_REGS, `BT_TEMP_LO, {a, b});
      nv_cmd(`BT_CMD_CYCLE_INC, NVC);
      nv_cmd(`BT_CMD_CYCLE_INC, NVC);
      expect_rd(`BT_CMD_RD_REGS, `BT_COUNT_LO, {8'h02, 8'h00, 8'hFF});
      nv_cmd(`BT_CMD_CYCLE_CLR, NVC);
      expect_rd(`BT_CMD_RD_REGS, `BT_COUNT_LO, {8'h00, 8'h00});
      // partial write, then an unknown code parks the engine
      m.send({`BT_CMD_WR_SCRATCH, 8'h10});
      m.send({8'h00, a, b});
      expect_rd(`BT_CMD_RD_SCRATCH, 8'h10,
         {8'h00, 8'h00, 8'h00});
      repeat (3) @(posedge ref_clk);
      check("pending reads", 16'(expq.size()), 16'h0000);
      test_done;
   end
endmodule
